// ==== pwm_output_mode_control.v ====
// PWM output stage: mode waveforms, dead band, enable, steering, polarity
//
// The address map and register access over Avalon-MM were left to the implementer.
`timescale 1ns/1ps

`include "pwm_out_defs.vh"

// Timing seen from the pins: an event pulse is taken at one edge,
// moves the internal level at that same edge and reaches the pin
// register one edge later. A dead band of d cycles holds back the
// incoming output of the complementary pair for d further edges, so
// both outputs of the pair rest inactive for exactly d cycles.
//
// The stage trusts its event inputs to be single-cycle pulses that
// are already synchronous to clk. A pulse held high for several
// cycles is taken again on each of them, and inside a dead band that
// restarts the count; the time base must not stretch its events.
// When a falling and a rising event meet in one cycle the falling
// one wins, so a zero-width pulse never reaches a switch.
//
// Steering written while the module runs waits in the buffer until
// the enable is next set from zero. A pattern written one register
// at a time can then never reach the switches half done; the price
// is a disable and enable cycle whenever the pattern must change.
//
// Only the pin enable decides who owns a pin. An enabled pin whose
// steering is off is still driven, at its inactive level, so it can
// never float and switch a transistor on by accident.
//
// Polarity is applied last, after steering and mode routing, so the
// inactive level of every pin, steered or not, is simply its
// polarity bit.
//
// Six-step operation shares the single-phase path: software moves
// the steering pattern between steps and the stage shows it on the
// next enable, the same as in single-phase mode.
//
// Register bus: every access costs exactly one wait state. Read data
// are captured in the wait cycle and stand at the completing edge,
// so readdata leaves straight from flip-flops.

module pwm_output_mode_control (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // Avalon-MM slave
  input  wire [4:0]  address,
  input  wire        read,
  input  wire        write,
  input  wire [31:0] writedata,
  output reg  [31:0] readdata,
  output wire        waitrequest,
  // Events from the time base
  input  wire        periodEvt,
  input  wire        riseEvt,
  input  wire        fallEvt,
  // Output pins
  output reg         pwmOutA,
  output reg         pwmOutB,
  output reg         pwmOutC,
  output reg         pwmOutD,
  output reg         pwmOutE,
  output reg         pwmOutF,
  output reg  [5:0]  pinOe
);

  // Dead-band sequencer states
  localparam [1:0] DB_IDLE = 2'b00;
  localparam [1:0] DB_RISE = 2'b01;
  localparam [1:0] DB_FALL = 2'b10;

  // Software registers
  reg  [7:0] ctrl;
  reg  [5:0] oen;
  reg  [5:0] steerBuf;
  reg  [5:0] steerAct;
  reg  [5:0] pol;
  reg  [7:0] dbRise;
  reg  [7:0] dbFall;

  // Waveform state
  reg        primOn;
  reg        compOn;
  reg        ppA;
  reg        ppB;
  reg        oddPeriod;
  reg        periodSeen;
  reg  [1:0] dbState;
  reg  [7:0] dbCnt;

  // Bus handshake
  reg        ack;
  wire       req;
  wire       wrTake;
  wire       enWrite;
  wire       rdTake;

  // Status readback
  wire        dbBusy;
  reg  [31:0] statusWord;

  // Decoded control
  wire       enabled;
  wire [3:0] mode;
  wire       steerMode;
  wire       complMode;
  wire       ppMode;
  wire [5:0] activeLvl;
  wire [5:0] nextPin;

  assign enabled   = ctrl[`CTRL_EN];
  assign mode      = ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
  assign complMode = (mode == `MODE_COMPL);
  assign ppMode    = (mode == `MODE_PP);
  // Steering counts only in single, complementary and six-step
  assign steerMode = (mode == `MODE_SINGLE) || complMode ||
                     (mode == `MODE_SIXSTEP);

  // One wait state per access keeps read data registered
  assign req         = read | write;
  assign waitrequest = req & ~ack;
  assign wrTake      = write & ack;
  assign enWrite     = wrTake && (address == `OFS_CTRL) &&
                       writedata[`CTRL_EN] && !enabled;
  // Read data are taken in the wait cycle, never at completion
  assign rdTake      = read & ~ack;
  assign dbBusy      = (dbState != DB_IDLE);

  // Acknowledge one cycle after a request appears. ack drops again at
  // the completing edge, so a request raised right after it starts
  // with ack low and gets its own wait state
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  // Register writes; a write counts only on the acknowledged edge.
  // STATUS is read-only and unmapped offsets fall to the default arm,
  // so a stray write there changes nothing
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl     <= `CTRL_RST;
      oen      <= `PIN_RST;
      steerBuf <= `PIN_RST;
      pol      <= `PIN_RST;
      dbRise   <= `DB_RST;
      dbFall   <= `DB_RST;
    end else if (wrTake) begin
      case (address)
        `OFS_CTRL:  ctrl     <= writedata[7:0];
        `OFS_OEN:   oen      <= writedata[5:0];
        `OFS_STEER: steerBuf <= writedata[5:0];
        `OFS_POL:   pol      <= writedata[5:0];
        `OFS_DBR:   dbRise   <= writedata[7:0];
        `OFS_DBF:   dbFall   <= writedata[7:0];
        default: ;
      endcase
    end
  end

  // Working steering copy; loaded only as the module is switched on,
  // so a half-written steering pattern never reaches the pins
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      steerAct <= `PIN_RST;
    end else if (enWrite) begin
      steerAct <= steerBuf;
    end
  end

  // Status word, fields at their defined bit positions; activeLvl is
  // the level before polarity, so software sees what the stage means
  // and not what the pin happens to show
  always @* begin
    statusWord               = 32'h0000_0000;
    statusWord[5:0]          = activeLvl;
    statusWord[`STAT_ODD]    = oddPeriod;
    statusWord[`STAT_DBBUSY] = dbBusy;
  end

  // Read data captured in the wait cycle, valid at the release edge
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata <= 32'h0000_0000;
    end else if (rdTake) begin
      case (address)
        `OFS_CTRL:   readdata <= {24'h00_0000, ctrl};
        `OFS_OEN:    readdata <= {26'h000_0000, oen};
        `OFS_STEER:  readdata <= {26'h000_0000, steerBuf};
        `OFS_POL:    readdata <= {26'h000_0000, pol};
        `OFS_DBR:    readdata <= {24'h00_0000, dbRise};
        `OFS_DBF:    readdata <= {24'h00_0000, dbFall};
        `OFS_STATUS: readdata <= statusWord;
        default:     readdata <= 32'h0000_0000;
      endcase
    end
  end

  // Odd/even tracking: the first period event opens period one (odd).
  // A rise that comes before any period event is treated as odd too,
  // so push-pull always starts on output A after enable
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      oddPeriod  <= 1'b1;
      periodSeen <= 1'b0;
    end else if (!enabled) begin
      oddPeriod  <= 1'b1;
      periodSeen <= 1'b0;
    end else if (periodEvt) begin
      periodSeen <= 1'b1;
      oddPeriod  <= periodSeen ? ~oddPeriod : 1'b1;
    end
  end

  // Push-pull pulses, no dead band; a fall beats a rise in one cycle.
  // Both pulses are cleared outside push-pull so that a later switch
  // into it cannot resume an old half period
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ppA <= 1'b0;
      ppB <= 1'b0;
    end else if (!enabled || !ppMode) begin
      ppA <= 1'b0;
      ppB <= 1'b0;
    end else if (fallEvt) begin
      ppA <= 1'b0;
      ppB <= 1'b0;
    end else if (riseEvt) begin
      ppA <= oddPeriod;
      ppB <= ~oddPeriod;
    end
  end

  // Primary and complementary levels with the dead-band sequencer.
  // Single and six-step modes never start a dead band, so the
  // primary follows the events directly.
  // A new event in the middle of a dead band restarts the sequencer,
  // and the counter is only read while a band is running.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      primOn  <= 1'b0;
      compOn  <= 1'b0;
      dbState <= DB_IDLE;
      dbCnt   <= 8'h00;
    end else if (!enabled || ppMode) begin
      primOn  <= 1'b0;
      compOn  <= 1'b0;
      dbState <= DB_IDLE;
      dbCnt   <= 8'h00;
    end else if (fallEvt) begin
      primOn <= 1'b0;
      if (!complMode) begin
        compOn  <= 1'b0;
        dbState <= DB_IDLE;
      end else if (ctrl[`CTRL_DBF_EN] && dbFall != 8'h00) begin
        compOn  <= 1'b0;
        dbState <= DB_FALL;
        dbCnt   <= dbFall;
      end else begin
        compOn  <= 1'b1;
        dbState <= DB_IDLE;
      end
    end else if (riseEvt) begin
      compOn <= 1'b0;
      if (!complMode) begin
        primOn  <= 1'b1;
        dbState <= DB_IDLE;
      end else if (ctrl[`CTRL_DBR_EN] && dbRise != 8'h00) begin
        primOn  <= 1'b0;
        dbState <= DB_RISE;
        dbCnt   <= dbRise;
      end else begin
        primOn  <= 1'b1;
        dbState <= DB_IDLE;
      end
    end else begin
      case (dbState)
        DB_RISE: begin
          if (dbCnt == 8'h01) begin
            primOn  <= 1'b1;
            dbState <= DB_IDLE;
          end
          dbCnt <= dbCnt - 8'h01;
        end
        DB_FALL: begin
          if (dbCnt == 8'h01) begin
            compOn  <= 1'b1;
            dbState <= DB_IDLE;
          end
          dbCnt <= dbCnt - 8'h01;
        end
        default: begin
          dbState <= DB_IDLE;
        end
      endcase
    end
  end

  // Per-pin active level: mode routing, then steering mask.
  // Pin F has no complementary role, so it stays inactive in that
  // mode even when steered; invalid mode codes leave every pin off
  genvar i;
  generate
    for (i = 0; i < 6; i = i + 1) begin : gPin
      reg src;
      always @* begin
        src = 1'b0;
        if (ppMode) begin
          // Fixed A/B pair, steering ignored
          if (i == `PIN_A) src = ppA;
          if (i == `PIN_B) src = ppB;
        end else if (complMode) begin
          // E carries the primary when steered
          if (i == `PIN_A || i == `PIN_C || i == `PIN_E)
            src = primOn & steerAct[i];
          else if (i == `PIN_B || i == `PIN_D)
            src = compOn & steerAct[i];
        end else if (steerMode) begin
          src = primOn & steerAct[i];
        end
      end
      assign activeLvl[i] = src;
      // Polarity flips active and inactive per pin
      assign nextPin[i] = src ^ pol[i];
    end
  endgenerate

  // Registered pins; the enable alone decides who owns each pin.
  // Registering the pins costs one cycle of latency but keeps any
  // decode glitch from ever reaching the gate drivers
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      pwmOutA <= 1'b0;
      pwmOutB <= 1'b0;
      pwmOutC <= 1'b0;
      pwmOutD <= 1'b0;
      pwmOutE <= 1'b0;
      pwmOutF <= 1'b0;
      pinOe   <= `PIN_RST;
    end else begin
      pwmOutA <= nextPin[`PIN_A];
      pwmOutB <= nextPin[`PIN_B];
      pwmOutC <= nextPin[`PIN_C];
      pwmOutD <= nextPin[`PIN_D];
      pwmOutE <= nextPin[`PIN_E];
      pwmOutF <= nextPin[`PIN_F];
      pinOe   <= oen;
    end
  end

endmodule // pwm_output_mode_control

// ==== pwm_out_defs.vh ====
// Constants for the PWM output mode control block
`ifndef PWM_OUT_DEFS_VH
`define PWM_OUT_DEFS_VH

// Register byte offsets
`define OFS_CTRL    5'h00
`define OFS_OEN     5'h04
`define OFS_STEER   5'h08
`define OFS_POL     5'h0C
`define OFS_DBR     5'h10
`define OFS_DBF     5'h14
`define OFS_STATUS  5'h18

// Control register fields
`define CTRL_EN     7
`define CTRL_DBR_EN 5
`define CTRL_DBF_EN 4
`define CTRL_MODE_HI 3
`define CTRL_MODE_LO 0

// Mode codes
`define MODE_SINGLE 4'h0
`define MODE_COMPL  4'h1
`define MODE_PP     4'h2
`define MODE_SIXSTEP 4'h3

// Reset values
`define CTRL_RST    8'h00
`define PIN_RST     6'h00
`define DB_RST      8'h00

// Status register fields
`define STAT_ODD    8
`define STAT_DBBUSY 9

// Pin indices
`define PIN_A 0
`define PIN_B 1
`define PIN_C 2
`define PIN_D 3
`define PIN_E 4
`define PIN_F 5

`endif

// ==== pin_bank.sv ====
// Model of the port pins that the PWM outputs drive
`timescale 1ns/1ps
module pin_bank (
  // From the output stage
  input  wire [5:0] pwm,
  input  wire [5:0] pinOe,
  // Other pin owner and resulting level
  input  wire [5:0] gpio,
  output wire [5:0] pinLevel
);
  // Stage owns a pin only while enabled, else the port driver wins
  assign pinLevel = (pinOe & pwm) | (~pinOe & gpio);
endmodule // pin_bank

// ==== pwm_out_asserts.sv ====
// Port checker for the PWM output stage
`timescale 1ns/1ps
`include "pwm_out_defs.vh"
module pwm_out_asserts (
  // Clock, reset and bus
  input wire        clk,
  input wire        rst,
  input wire [4:0]  address,
  input wire        read,
  input wire        write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire        waitrequest,
  // Events
  input wire        riseEvt,
  input wire        fallEvt,
  // Pins
  input wire        pwmOutA,
  input wire        pwmOutB,
  input wire        pwmOutC,
  input wire        pwmOutD,
  input wire        pwmOutE,
  input wire        pwmOutF,
  input wire [5:0]  pinOe
);
  reg  [7:0] ctl;
  reg  [5:0] pol;
  wire       wr = write && !waitrequest;
  wire [5:0] outs = {pwmOutF, pwmOutE, pwmOutD, pwmOutC, pwmOutB, pwmOutA};
  wire       sg = ctl[7] && ctl[3:0] == `MODE_SINGLE;
  wire       pp = ctl[7] && ctl[3:0] == `MODE_PP;
  // Shadow of mode and polarity, so pin levels can be judged
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      ctl <= 8'h00;
      pol <= 6'h00;
    end else if (wr && address == `OFS_CTRL) ctl <= writedata[7:0];
    else if (wr && address == `OFS_POL) pol <= writedata[5:0];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  property p_wait; (read || write) && waitrequest |=> !waitrequest; endproperty
  a_wait: assert property (p_wait) else $error("wait too long");
  property p_idle; !(read || write) |-> !waitrequest; endproperty
  a_idle: assert property (p_idle) else $error("idle wait");
  property p_rd; $changed(readdata) |-> $past(read); endproperty
  a_rd: assert property (p_rd) else $error("stray read data");
  property p_oe;
    $changed(pinOe) |-> $past(wr && address == `OFS_OEN)
      || $past(wr && address == `OFS_OEN, 2);
  endproperty
  a_oe: assert property (p_oe) else $error("enable moved alone");
  property p_sfall; sg && fallEvt && !write |-> ##2 outs == pol; endproperty
  a_sfall: assert property (p_sfall) else $error("fall left pin on");
  property p_ppoff; pp && fallEvt && !write |-> ##2 outs == pol; endproperty
  a_ppoff: assert property (p_ppoff) else $error("pp fall");
  property p_ppone;
    pp && riseEvt && !fallEvt |-> ##2 (outs[0] ^ pol[0]) != (outs[1] ^ pol[1]);
  endproperty
  a_ppone: assert property (p_ppone) else $error("pp not one pin");
  property p_ppcf; pp && riseEvt |-> ##2 outs[5:2] == pol[5:2]; endproperty
  a_ppcf: assert property (p_ppcf) else $error("pp used C to F");
  property p_off;
    !ctl[7] && $past(!ctl[7]) && $past(!ctl[7], 2) && $stable(pol)
      |-> outs == pol;
  endproperty
  a_off: assert property (p_off) else $error("off but active");
  c_single: cover property (sg && riseEvt);
  c_pp: cover property (pp && riseEvt);
  c_off: cover property (!ctl[7] && riseEvt);
endmodule // pwm_out_asserts
bind pwm_output_mode_control pwm_out_asserts chk_u (.clk, .rst, .address,
  .read, .write, .writedata, .readdata, .waitrequest, .riseEvt, .fallEvt,
  .pwmOutA, .pwmOutB, .pwmOutC, .pwmOutD, .pwmOutE, .pwmOutF, .pinOe);

// ==== pwm_output_mode_control_test.sv ====
// Self-checking bench for the PWM output stage
`timescale 1ns/1ps
`include "pwm_out_defs.vh"
module pwm_output_mode_control_test;
  // Bus, events, pins and bench state
  reg         clk = 1'h0, rst = 1'h1, read = 1'h0, write = 1'h0;
  reg  [4:0]  address = 5'h0;
  reg  [31:0] writedata = 32'h0, rd, seed = 32'h0000_8bb7;
  reg         periodEvt = 1'h0, riseEvt = 1'h0, fallEvt = 1'h0;
  reg  [5:0]  gpio = 6'h0, o, p, s;
  wire [31:0] readdata;
  wire        waitrequest, pwmOutA, pwmOutB, pwmOutC, pwmOutD, pwmOutE;
  wire        pwmOutF;
  wire [5:0]  pinOe, pinLevel;
  integer     n_mismatch = 0, n_compared = 0, i, k, d;
  pwm_output_mode_control dut_u (.clk, .rst, .address, .read, .write,
    .writedata, .readdata, .waitrequest, .periodEvt, .riseEvt, .fallEvt,
    .pwmOutA, .pwmOutB, .pwmOutC, .pwmOutD, .pwmOutE, .pwmOutF, .pinOe);
  pin_bank bank_u (.pwm({pwmOutF, pwmOutE, pwmOutD, pwmOutC, pwmOutB,
    pwmOutA}), .pinOe, .gpio, .pinLevel);
  always #50 clk = ~clk;
  function [31:0] xs(input [31:0] v);
    reg [31:0] x;
    begin
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      xs = x ^ (x << 5);
    end
  endfunction
  // Expected pin level from active set a and polarity pl
  function [5:0] pins(input [5:0] a, input [5:0] pl);
    pins = (o & (a ^ pl)) | (~o & gpio);
  endfunction
  task chk(input [8*5:1] nm, input [31:0] e, input [31:0] g);
    begin
      n_compared = n_compared + 1;
      if (e !== g) begin
        n_mismatch = n_mismatch + 1;
        $display("[ERR] %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  // One bus access; held until waitrequest is seen low
  task bus(input wr, input [4:0] a, input [31:0] dt);
    begin
      @(posedge clk);
      address <= a;
      writedata <= dt;
      write <= wr;
      read <= !wr;
      k = 0;
      @(posedge clk);
      while (waitrequest !== 1'h0 && k < 20) begin
        k = k + 1;
        @(posedge clk);
      end
      if (k == 20) n_mismatch = n_mismatch + 1;
      rd = readdata;
      write <= 1'h0;
      read <= 1'h0;
    end
  endtask
  // Pulse event w (0 period, 1 rise, 2 fall), then wait n edges
  task ev(input [1:0] w, input integer n);
    begin
      @(posedge clk);
      {fallEvt, riseEvt, periodEvt} <= 3'h1 << w;
      @(posedge clk);
      {fallEvt, riseEvt, periodEvt} <= 3'h0;
      repeat (n) @(posedge clk);
      #1;
    end
  endtask
  task close_out;
    begin
      $display("Counts: %0d compared, %0d mismatched", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  // Watchdog well past the expected run
  initial begin
    #3_000_000;
    n_mismatch = n_mismatch + 1;
    close_out;
  end
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'h0;
    for (i = 0; i < 8; i = i + 1) begin
      seed = xs(seed);
      if (i != 6) bus(1'h0, {i[2:0], 2'h0}, 32'h0);
      if (i != 6) chk("rst", 32'h0, rd);
      if (i != 6) bus(1'h1, {i[2:0], 2'h0}, seed);
      if (i != 6) bus(1'h0, {i[2:0], 2'h0}, 32'h0);
      if (i != 6) chk("rdbk", seed & (i == 0 ? 32'hff : i < 4 ? 32'h3f :
        i < 6 ? 32'hff : 32'h0), rd);
    end
    $display("test registers done");
    // Single and six-step: buffered steering, random enable and polarity
    for (i = 0; i < 4; i = i + 1) begin
      seed = xs(seed);
      {s, p, o} = seed[17:0];
      gpio <= seed[23:18];
      bus(1'h1, `OFS_CTRL, 32'h0);
      bus(1'h1, `OFS_OEN, o);
      bus(1'h1, `OFS_POL, p);
      bus(1'h1, `OFS_STEER, s);
      bus(1'h1, `OFS_CTRL, i[0] ? 32'hb3 : 32'hb0);
      bus(1'h1, `OFS_STEER, ~s);
      chk("oe", o, pinOe);
      ev(1, 2); chk("rise", pins(s, p), pinLevel);
      ev(2, 2); chk("fall", pins(6'h0, p), pinLevel);
    end
    $display("test single done");
    // Complementary with dead band of 1, 4 and 7 cycles
    o = 6'h3f;
    for (i = 1; i < 4; i = i + 1) begin
      d = i * 3 - 2;
      bus(1'h1, `OFS_CTRL, 32'h0);
      bus(1'h1, `OFS_OEN, 32'h3f);
      bus(1'h1, `OFS_POL, 32'h0);
      bus(1'h1, `OFS_STEER, 32'h0f);
      bus(1'h1, `OFS_DBR, d);
      bus(1'h1, `OFS_DBF, d);
      bus(1'h1, `OFS_CTRL, 32'hb1);
      ev(1, d); chk("dbr", pins(6'h0, 6'h0), pinLevel);
      @(posedge clk); #1; chk("pri", pins(6'h05, 6'h0), pinLevel);
      ev(2, d); chk("dbf", pins(6'h0, 6'h0), pinLevel);
      @(posedge clk); #1; chk("cmp", pins(6'h0a, 6'h0), pinLevel);
      ev(1, d); chk("dbr2", pins(6'h0, 6'h0), pinLevel);
    end
    $display("test complementary done");
    // Push-pull alternates A and B, steering ignored
    seed = xs(seed);
    p = seed[5:0];
    bus(1'h1, `OFS_CTRL, 32'h0);
    bus(1'h1, `OFS_POL, p);
    bus(1'h1, `OFS_STEER, 32'h3f);
    bus(1'h1, `OFS_CTRL, 32'hb2);
    for (i = 0; i < 4; i = i + 1) begin
      ev(0, 0);
      ev(1, 2); chk("pp", pins(i[0] ? 6'h2 : 6'h1, p), pinLevel);
      ev(2, 2); chk("ppoff", pins(6'h0, p), pinLevel);
    end
    bus(1'h1, `OFS_CTRL, 32'h85);
    ev(1, 2); chk("bad", pins(6'h0, p), pinLevel);
    bus(1'h1, `OFS_CTRL, 32'h0);
    ev(1, 2); chk("off", pins(6'h0, p), pinLevel);
    bus(1'h1, `OFS_CTRL, 32'h82);
    ev(1, 2); chk("odd", pins(6'h1, p), pinLevel);
    bus(1'h0, `OFS_STATUS, 32'h0);
    chk("stat", 32'h1 | (32'h1 << `STAT_ODD), rd);
    $display("test push-pull done");
    close_out;
  end
endmodule // pwm_output_mode_control_test
